// >>> spr_backplane_model.sv
// Behavioural model of the other modules sharing the backplane sync lines.
`timescale 1ns/1ps
module spr_backplane_model (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   // Lines as driven by the router.
   input wire logic [1:0] lineOut,
   input wire logic [1:0] lineOe,
   // Resolved wire levels.
   output logic [1:0] wireLevel
);
   logic [1:0] floatLevel;
   // An undriven line wanders every cycle, so a missing enable never passes for a quiet low.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         floatLevel <= 2'h0;
      end else begin
         floatLevel <= ~wireLevel;
      end
   end
   assign wireLevel = (lineOe & lineOut) | (~lineOe & floatLevel);
endmodule

// >>> spr_line_mux.sv
// Per-line feed selection and enable gating for one backplane sync line.
`timescale 1ns/1ps
module spr_line_mux (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   // Settings.
   input wire logic [1:0] feed,
   input wire logic lineEnable,
   input wire logic frontEnable,
   // Sources.
   input wire logic frontSignal,
   input wire logic refClock,
   input wire logic refExternal,
   input wire logic convertPulse,
   // Line.
   output logic lineOut,
   output logic lineOe
);
   import spr_pkg::*;
   typedef struct packed {
      logic out;
      logic oe;
   } spr_lm_state_t;
   spr_lm_state_t st, next_st;
   always_comb begin
      next_st.out = 1'b0;
      next_st.oe = lineEnable;
      case (feed)
         SPR_FEED_FRONT: begin
            next_st.out = ~frontSignal;
            next_st.oe = lineEnable & frontEnable;
         end
         // External reference: line follows its inverse so it rises on the falling edge.
         SPR_FEED_REFCLK: begin
            next_st.out = refExternal ? ~refClock : refClock;
         end
         SPR_FEED_CONVERT: begin
            next_st.out = convertPulse;
         end
         default: begin
            next_st.oe = 1'b0;
         end
      endcase
      if (!next_st.oe) begin
         next_st.out = 1'b0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else if (clockEnable) begin
         st <= next_st;
      end
   end
   assign lineOut = st.out;
   assign lineOe = st.oe;
endmodule

// >>> spr_pkg.sv
// Package for the sync pulse trigger router: register map, fields, reset values, timing.
package spr_pkg;
   // Register byte offsets.
   localparam logic [7:0] SPR_REG_CTRL = 8'h00;
   localparam logic [7:0] SPR_REG_STATUS = 8'h04;
   localparam logic [7:0] SPR_REG_USAGE = 8'h08;
   localparam logic [7:0] SPR_REG_CMD = 8'h0c;
   // Feed selector encodings.
   localparam logic [1:0] SPR_FEED_FRONT = 2'h0;
   localparam logic [1:0] SPR_FEED_REFCLK = 2'h1;
   localparam logic [1:0] SPR_FEED_CONVERT = 2'h2;
   // Front connector source encodings.
   localparam logic [1:0] SPR_FRONT_ARM = 2'h0;
   localparam logic [1:0] SPR_FRONT_READY = 2'h1;
   localparam logic [1:0] SPR_FRONT_CONVERT = 2'h2;
   localparam logic [1:0] SPR_FRONT_REFCLK = 2'h3;
   // CTRL fields.
   localparam int SPR_CTRL_FEED0_LSB = 0;
   localparam int SPR_CTRL_FEED1_LSB = 2;
   localparam int SPR_CTRL_EN0_BIT = 4;
   localparam int SPR_CTRL_EN1_BIT = 5;
   localparam int SPR_CTRL_FRONT_EN_BIT = 6;
   localparam int SPR_CTRL_FRONT_SRC_LSB = 8;
   localparam int SPR_CTRL_LBUS_BIT = 10;
   localparam int SPR_CTRL_SBUS_BIT = 11;
   // STATUS fields.
   localparam int SPR_STAT_CONFLICT_BIT = 0;
   localparam int SPR_STAT_BUSY_BIT = 1;
   localparam int SPR_STAT_LINE_LSB = 2;
   // CMD fields.
   localparam int SPR_CMD_MEASURE_BIT = 0;
   localparam int SPR_CMD_CLRERR_BIT = 1;
   // Reset values: line 0 convert feed, line 1 front feed, everything off.
   localparam logic [1:0] SPR_RST_FEED0 = SPR_FEED_CONVERT;
   localparam logic [1:0] SPR_RST_FEED1 = SPR_FEED_FRONT;
   localparam logic [1:0] SPR_RST_FRONT_SRC = SPR_FRONT_CONVERT;
   // Bus answers.
   localparam logic [1:0] SPR_RESP_OKAY = 2'h0;
   localparam logic [1:0] SPR_RESP_SLVERR = 2'h2;
   localparam logic [1:0] SPR_RESP_DECERR = 2'h3;
   // Convert pulse width.
   localparam int SPR_CLK_PERIOD_NS = 10;
   localparam int SPR_PULSE_NS = 25;
   localparam int SPR_PULSE_CYCLES = (SPR_PULSE_NS + SPR_CLK_PERIOD_NS - 1) / SPR_CLK_PERIOD_NS;
endpackage

// >>> spr_pulse_gen.sv
// Fixed-width pulse stretcher for convert strobes.
`timescale 1ns/1ps
module spr_pulse_gen #(
   parameter int WIDTH = spr_pkg::SPR_PULSE_CYCLES
) (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   // Strobe in, pulse out.
   input wire logic strobe,
   output logic pulse
);
   import spr_pkg::*;
   typedef struct packed {
      logic [3:0] count;
   } spr_pg_state_t;
   spr_pg_state_t st, next_st;
   always_comb begin
      next_st = st;
      // A strobe during a pulse restarts it so back-to-back strobes still show.
      if (strobe) begin
         next_st.count = 4'(WIDTH);
      end else if (st.count != 4'h0) begin
         next_st.count = st.count - 4'h1;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else if (clockEnable) begin
         st <= next_st;
      end
   end
   assign pulse = (st.count != 4'h0);
endmodule

// >>> spr_sync_pulse_trigger_router.sv
// Top of the sync pulse trigger router with its AXI4-Lite register slave.
// How it works
// - Two backplane sync lines 0 and 1, each with front, refclock or convert feed.
// - Front feed drives the chosen front connector signal inverted.
// - Front feed drives only when front enable and line enable are both set.
// - Refclock rises on external reference falling edge, else on rising edge.
// - Enabled refclock feed runs continuously until another feed is chosen.
// - Convert feed gives one 3-cycle (30 ns) positive pulse per converter strobe.
// - Convert pulses also come during local or system bus readout.
// - Each line keeps its own feed selection.
// - Each line has its own enable gating its output.
// - Enabling a line already used as a source raises a conflict error.
// - Feed and enable writes to CTRL are refused while an acquisition is initiated; the measure command is not.
// - Measure command disables outputs, resets feeds, stops readout; states persist.
// - Arm source on front feed goes low at arm event until samples done.
// - Ready source goes low after arm delay until samples done.
`timescale 1ns/1ps
module spr_sync_pulse_trigger_router
   import spr_pkg::*;
#(
   parameter int LINES = 2,
   parameter int PULSE_CYCLES = spr_pkg::SPR_PULSE_CYCLES
) (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   // AXI4-Lite write.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Acquisition state.
   input wire logic initiated,
   input wire logic convertStrobe,
   input wire logic readoutStrobe,
   input wire logic armEvent,
   input wire logic armDelayDone,
   input wire logic samplesDone,
   // Reference clock.
   input wire logic refClock,
   input wire logic refExternal,
   // Lines used as sources elsewhere, one bit per line.
   input wire logic [1:0] lineInUse,
   // Backplane sync lines.
   output logic [1:0] backplaneSyncLineOut,
   output logic [1:0] backplaneSyncLineOe,
   // Readout path enables.
   output logic localBusReadout,
   output logic systemBusReadout
);
   typedef struct packed {
      logic [1:0] feed0;
      logic [1:0] feed1;
      logic [1:0] lineEn;
      logic frontEn;
      logic [1:0] frontSrc;
      logic lbus;
      logic sbus;
      logic conflict;
      logic armLow;
      logic readyLow;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } spr_state_t;
   spr_state_t st, next_st;
   logic convertPulse;
   logic frontSignal;
   logic [1:0] feedOf [2];

   function automatic logic known(input logic [7:0] a);
      known = (a == SPR_REG_CTRL) || (a == SPR_REG_STATUS) ||
              (a == SPR_REG_USAGE) || (a == SPR_REG_CMD);
   endfunction

   // Readout strobes share the stretcher with converter strobes.
   spr_pulse_gen #(.WIDTH(PULSE_CYCLES)) u_pulse (
      .clock(clock),
      .rst(rst),
      .clockEnable(clockEnable),
      .strobe(convertStrobe | readoutStrobe),
      .pulse(convertPulse)
   );

   // Front connector arm, ready and convert signals are normally high and pulled low while active; refclock follows external, inverts internal reference.
   always_comb begin
      case (st.frontSrc)
         SPR_FRONT_ARM: frontSignal = ~st.armLow;
         SPR_FRONT_READY: frontSignal = ~st.readyLow;
         SPR_FRONT_CONVERT: frontSignal = ~convertPulse;
         SPR_FRONT_REFCLK: frontSignal = refExternal ? refClock : ~refClock;
         default: frontSignal = 1'b1;
      endcase
   end

   assign feedOf[0] = st.feed0;
   assign feedOf[1] = st.feed1;

   for (genvar i = 0; i < LINES; i++) begin : g_line
      spr_line_mux u_mux (
         .clock(clock),
         .rst(rst),
         .clockEnable(clockEnable),
         .feed(feedOf[i]),
         .lineEnable(st.lineEn[i]),
         .frontEnable(st.frontEn),
         .frontSignal(frontSignal),
         .refClock(refClock),
         .refExternal(refExternal),
         .convertPulse(convertPulse),
         .lineOut(backplaneSyncLineOut[i]),
         .lineOe(backplaneSyncLineOe[i])
      );
   end

   always_comb begin
      logic doWrite;
      logic [31:0] wd;
      logic [1:0] reqEn;
      doWrite = 1'b0;
      wd = '0;
      reqEn = '0;
      next_st = st;
      // Arm and ready levels; set wins over the end of the cycle.
      if (armEvent) begin
         next_st.armLow = 1'b1;
      end else if (samplesDone) begin
         next_st.armLow = 1'b0;
      end
      if (armDelayDone) begin
         next_st.readyLow = 1'b1;
      end else if (samplesDone) begin
         next_st.readyLow = 1'b0;
      end
      // Write channels may arrive in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.wHeld = 1'b1;
         next_st.wData = s_axi_wdata;
         next_st.wStrb = s_axi_wstrb;
      end
      if (st.awHeld && st.wHeld && !st.bValid) begin
         doWrite = 1'b1;
         wd = st.wData;
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.bValid = 1'b1;
         next_st.bResp = known(st.awAddr) ? SPR_RESP_OKAY : SPR_RESP_DECERR;
      end
      if (st.bValid && s_axi_bready) begin
         next_st.bValid = 1'b0;
      end
      if (doWrite && st.awAddr == SPR_REG_CTRL && st.wStrb[0]) begin
         if (initiated) begin
            next_st.bResp = SPR_RESP_SLVERR;
         end else begin
            reqEn = wd[SPR_CTRL_EN1_BIT:SPR_CTRL_EN0_BIT];
            // A newly enabled line that is busy elsewhere is refused.
            if ((reqEn & ~st.lineEn & lineInUse) != 2'h0) begin
               next_st.conflict = 1'b1;
               next_st.bResp = SPR_RESP_SLVERR;
            end else begin
               next_st.feed0 = wd[SPR_CTRL_FEED0_LSB +: 2];
               next_st.feed1 = wd[SPR_CTRL_FEED1_LSB +: 2];
               next_st.lineEn = reqEn;
               next_st.frontEn = wd[SPR_CTRL_FRONT_EN_BIT];
            end
         end
      end
      if (doWrite && st.awAddr == SPR_REG_CTRL && st.wStrb[1] && !initiated) begin
         next_st.frontSrc = wd[SPR_CTRL_FRONT_SRC_LSB +: 2];
         next_st.lbus = wd[SPR_CTRL_LBUS_BIT];
         next_st.sbus = wd[SPR_CTRL_SBUS_BIT];
      end
      if (doWrite && st.awAddr == SPR_REG_CMD && st.wStrb[0]) begin
         if (wd[SPR_CMD_CLRERR_BIT]) begin
            next_st.conflict = 1'b0;
         end
         if (wd[SPR_CMD_MEASURE_BIT]) begin
            next_st.lineEn = '0;
            next_st.frontEn = 1'b0;
            next_st.feed0 = SPR_RST_FEED0;
            next_st.feed1 = SPR_RST_FEED1;
            next_st.frontSrc = SPR_RST_FRONT_SRC;
            next_st.lbus = 1'b0;
            next_st.sbus = 1'b0;
         end
      end
      // Read channel.
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rValid = 1'b1;
         next_st.rResp = known(s_axi_araddr) ? SPR_RESP_OKAY : SPR_RESP_DECERR;
         next_st.rData = '0;
         case (s_axi_araddr)
            SPR_REG_CTRL: begin
               next_st.rData[SPR_CTRL_FEED0_LSB +: 2] = st.feed0;
               next_st.rData[SPR_CTRL_FEED1_LSB +: 2] = st.feed1;
               next_st.rData[SPR_CTRL_EN1_BIT:SPR_CTRL_EN0_BIT] = st.lineEn;
               next_st.rData[SPR_CTRL_FRONT_EN_BIT] = st.frontEn;
               next_st.rData[SPR_CTRL_FRONT_SRC_LSB +: 2] = st.frontSrc;
               next_st.rData[SPR_CTRL_LBUS_BIT] = st.lbus;
               next_st.rData[SPR_CTRL_SBUS_BIT] = st.sbus;
            end
            SPR_REG_STATUS: begin
               next_st.rData[SPR_STAT_CONFLICT_BIT] = st.conflict;
               next_st.rData[SPR_STAT_BUSY_BIT] = initiated;
               next_st.rData[SPR_STAT_LINE_LSB +: 2] = backplaneSyncLineOut;
            end
            SPR_REG_USAGE: begin
               next_st.rData[1:0] = lineInUse;
            end
            default: begin
               next_st.rData = '0;
            end
         endcase
      end else if (st.rValid && s_axi_rready) begin
         next_st.rValid = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.feed0 <= SPR_RST_FEED0;
         st.feed1 <= SPR_RST_FEED1;
         st.frontSrc <= SPR_RST_FRONT_SRC;
      end else if (clockEnable) begin
         st <= next_st;
      end
   end

   // Write channels are held off while a write waits for its response to drain, the read address while a read answer waits.
   assign s_axi_awready = clockEnable && !st.awHeld && !st.bValid;
   assign s_axi_wready = clockEnable && !st.wHeld && !st.bValid;
   assign s_axi_bvalid = st.bValid;
   assign s_axi_bresp = st.bResp;
   assign s_axi_arready = clockEnable && !st.rValid;
   assign s_axi_rvalid = st.rValid;
   assign s_axi_rdata = st.rData;
   assign s_axi_rresp = st.rResp;
   assign localBusReadout = st.lbus;
   assign systemBusReadout = st.sbus;
endmodule

// >>> spr_sync_pulse_trigger_router_properties.sv
// Concurrent checks on the router's bus handshakes and backplane line outputs.
`timescale 1ns/1ps
module spr_sync_pulse_trigger_router_properties (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Acquisition and lines.
   input wire logic initiated,
   input wire logic convertStrobe,
   input wire logic readoutStrobe,
   input wire logic [1:0] backplaneSyncLineOut,
   input wire logic [1:0] backplaneSyncLineOe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   chk_line_gated: assert property ((backplaneSyncLineOut & ~backplaneSyncLineOe) == 2'h0)
      else $error("line high while not driven");
   chk_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   chk_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped early");
   chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   chk_write_refused: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
      else $error("write taken while answer pending");
   chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   // The strobes are only pulsed while line 0 carries the convert feed.
   chk_pulse_shape: assert property ((convertStrobe || readoutStrobe) && backplaneSyncLineOe[0]
      |-> ##2 backplaneSyncLineOut[0] [*3] ##1 !backplaneSyncLineOut[0])
      else $error("convert pulse has wrong width or delay");
   chk_oe_frozen: assert property (initiated && $past(initiated) |-> $stable(backplaneSyncLineOe))
      else $error("line enable changed while initiated");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(backplaneSyncLineOut[0]));
endmodule

// >>> spr_sync_pulse_trigger_router_test.sv
// Self-checking testbench for the sync pulse trigger router.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module spr_sync_pulse_trigger_router_test;
   import spr_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic initiated = 1'b0;
   logic clockEnable = 1'b1;
   logic refClock = 1'b0;
   logic refExternal = 1'b0;
   logic [1:0] lineInUse = 2'b10;
   logic [4:0] ev = 5'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lineOut, lineOe, wireLevel;
   logic [31:0] s_axi_rdata;
   logic localBusReadout, systemBusReadout;
   logic [33:0] e;
   logic [33:0] expQ[$];
   int num_errors = 0;
   int checked = 0;
   int seed = 81;
   int n;

   always #5 clock = ~clock;

   spr_sync_pulse_trigger_router u_dut (.clock(clock), .rst(rst), .clockEnable(clockEnable),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .initiated(initiated),
      .convertStrobe(ev[0]), .readoutStrobe(ev[1]), .armEvent(ev[2]), .armDelayDone(ev[3]),
      .samplesDone(ev[4]), .refClock(refClock), .refExternal(refExternal),
      .lineInUse(lineInUse), .backplaneSyncLineOut(lineOut), .backplaneSyncLineOe(lineOe),
      .localBusReadout(localBusReadout), .systemBusReadout(systemBusReadout));

   spr_backplane_model u_far (.clock(clock), .rst(rst), .lineOut(lineOut), .lineOe(lineOe),
      .wireLevel(wireLevel));

   // Answers are taken off the queue at the falling edge before the handshake completes.
   always @(negedge clock) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
         e = expQ.pop_front();
         `CHK("bresp", e[33:32], s_axi_bresp)
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
         e = expQ.pop_front();
         `CHK("rresp", e[33:32], s_axi_rresp)
         `CHK("rdata", e[31:0], s_axi_rdata)
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, b;
      @(posedge clock);
      expQ.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clock);
         aw = s_axi_awready;
         w = s_axi_wready;
         b = s_axi_bvalid;
         @(posedge clock);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ar, ok;
      @(posedge clock);
      expQ.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ok = 1'b0;
      while (!ok) begin
         @(negedge clock);
         ar = s_axi_arready;
         ok = s_axi_rvalid;
         @(posedge clock);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic fire(input int k);
      @(posedge clock);
      ev[k] <= 1'b1;
      @(posedge clock);
      ev <= 5'h0;
   endtask

   task print_verdict;
      $display("Mismatches %0d of %0d comparisons", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      print_verdict;
   end

   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd(SPR_REG_CTRL, 32'h202, SPR_RESP_OKAY);
      rd(8'h10, 32'h0, SPR_RESP_DECERR);
      wr(SPR_REG_CTRL, 32'h212, SPR_RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         fire(k);
         n = 0;
         repeat (10) begin
            @(negedge clock);
            n += int'(wireLevel[0] & lineOe[0]);
         end
         `CHK("pulse cycles", 3, n)
      end
      wr(SPR_REG_CTRL, 32'h012, SPR_RESP_OKAY);
      wr(SPR_REG_CTRL, 32'h072, SPR_RESP_SLVERR);
      rd(SPR_REG_STATUS, 32'h1, SPR_RESP_OKAY);
      rd(SPR_REG_CTRL, 32'h012, SPR_RESP_OKAY);
      wr(SPR_REG_CMD, 32'h2, SPR_RESP_OKAY);
      lineInUse <= 2'b01;
      rd(SPR_REG_USAGE, 32'h1, SPR_RESP_OKAY);
      for (int s = 0; s < 2; s++) begin
         wr(SPR_REG_CTRL, {22'h0, 2'(s), 8'h72}, SPR_RESP_OKAY);
         fire(2);
         fire(3);
         repeat (4) @(posedge clock);
         `CHK("front active", 1'b1, wireLevel[1])
         fire(4);
         repeat (4) @(posedge clock);
         `CHK("front idle", 1'b0, wireLevel[1])
      end
      wr(SPR_REG_CTRL, 32'h032, SPR_RESP_OKAY);
      repeat (4) @(posedge clock);
      `CHK("front gate", 2'b01, lineOe)
      // Both lines carry the front feed with the front connector showing the internal reference.
      wr(SPR_REG_CTRL, 32'h370, SPR_RESP_OKAY);
      refClock <= 1'($random(seed));
      repeat (4) @(posedge clock);
      `CHK("front refclk", {2{refClock}}, wireLevel)
      wr(SPR_REG_CTRL, 32'h011, SPR_RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
         @(posedge clock);
         refExternal <= k[2];
         refClock <= 1'($random(seed));
         repeat (5) @(posedge clock);
         `CHK("refclk line", refClock ^ refExternal, wireLevel[0])
      end
      // With the clock enable low the line must hold its last level.
      clockEnable <= 1'b0;
      refClock <= ~refClock;
      repeat (3) @(posedge clock);
      `CHK("frozen line", ~(refClock ^ refExternal), wireLevel[0])
      clockEnable <= 1'b1;
      initiated <= 1'b1;
      wr(SPR_REG_CTRL, 32'h013, SPR_RESP_SLVERR);
      rd(SPR_REG_CTRL, 32'h011, SPR_RESP_OKAY);
      initiated <= 1'b0;
      wr(SPR_REG_CTRL, 32'hc11, SPR_RESP_OKAY);
      `CHK("readout on", 2'b11, {localBusReadout, systemBusReadout})
      wr(SPR_REG_CMD, 32'h1, SPR_RESP_OKAY);
      rd(SPR_REG_CTRL, 32'h202, SPR_RESP_OKAY);
      `CHK("measure off", 4'h0, {lineOe, localBusReadout, systemBusReadout})
      repeat (4) @(posedge clock);
      print_verdict;
   end
endmodule

bind spr_sync_pulse_trigger_router spr_sync_pulse_trigger_router_properties u_props (
   .clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .initiated(initiated),
   .convertStrobe(convertStrobe), .readoutStrobe(readoutStrobe),
   .backplaneSyncLineOut(backplaneSyncLineOut), .backplaneSyncLineOe(backplaneSyncLineOe));
